// >>> mbus_consts.svh
/*
 * Constants of the memory bus requester: register offsets, field
 * positions, reset values and settle timing.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef MBUS_CONSTS_SVH
`define MBUS_CONSTS_SVH

`define CLK_PERIOD_NS   40
`define T_SETTLE_NS     50
// Least time, so round up to whole cycles
`define SETTLE_CYC      ((`T_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_W          17
`define DATA_W          18
`define LINE_W          18

`define OFF_ADDR        8'h00
`define OFF_WDATA       8'h04
`define OFF_CTRL        8'h08
`define OFF_STATUS      8'h0C
`define OFF_RDATA       8'h10

`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    1
`define CTRL_START      4
`define CTRL_CONT       5
`define ST_BUSY         0
`define ST_PAUSE        1
`define ST_DONE         2
`define PAR_BIT         18

`define MODE_RESET      2'h1
`define HTRANS_NSEQ     1

`endif

// >>> mbus_pkg.sv
/*
 * Types shared by the memory bus requester modules.
 * Assumes nothing of its surroundings.
 */
package mbus_pkg;
	// Bit 0 asks for a read, bit 1 for a write
	typedef enum logic [1:0] {
		MODE_NONE = 2'h0,
		MODE_RR   = 2'h1,
		MODE_CW   = 2'h2,
		MODE_RPW  = 2'h3
	} mode_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_FREE,
		ST_ASET,
		ST_AACK,
		ST_RDV,
		ST_PAUSE,
		ST_DSET,
		ST_RACK,
		ST_END
	} state_t;
endpackage

// >>> ctl_if.sv
/*
 * Carrier between the register slave and the cycle sequencer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface ctl_if;
	logic                start;
	logic                cont;
	mbus_pkg::mode_t     mode;
	logic [16:0]         addr;
	logic [18:0]         wdata;
	logic [18:0]         rdata;
	logic                busy;
	logic                pause;
	logic                done;

	modport regs (
		output start, cont, mode, addr, wdata,
		input  rdata, busy, pause, done
	);
	modport core (
		input  start, cont, mode, addr, wdata,
		output rdata, busy, pause, done
	);
endinterface

// >>> settle_timer.sv
/*
 * Settle timer: counts while run is high, expired once LIMIT reached.
 * Assumes run drops between uses so the count restarts.
 */
`timescale 1ns/100ps
module settle_timer #(
	parameter int W     = 4,
	parameter int LIMIT = 2
) (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ce,
	// Control
	input  wire logic run,
	output logic      expired
);
	logic [W-1:0] cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
		end else if (ce) begin
			if (!run)
				cnt <= '0;
			else if (cnt != W'(LIMIT))
				cnt <= cnt + W'(1);
		end
	end

	assign expired = run && (cnt == W'(LIMIT));
endmodule

// >>> ahb_regs.sv
/*
 * AHB-Lite slave holding the requester's command and status words.
 * Assumes single word transfers; answers with no wait state.
 */
`timescale 1ns/100ps
`include "mbus_consts.svh"
module ahb_regs (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Sequencer side
	ctl_if.regs              ctl
);
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic       done_flag;
	logic       acc;

	assign acc = hsel && hready && htrans[`HTRANS_NSEQ];

	function automatic logic [31:0] read_word(input logic [7:0] a);
		case (a)
		`OFF_ADDR:   read_word = {15'h0000, ctl.addr};
		`OFF_WDATA:  read_word = {13'h0000, ctl.wdata};
		`OFF_CTRL:   read_word = {30'h00000000, ctl.mode};
		`OFF_STATUS: read_word = {29'h00000000, done_flag, ctl.pause,
			ctl.busy};
		`OFF_RDATA:  read_word = {13'h0000, ctl.rdata};
		default:     read_word = 32'h00000000;
		endcase
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (ce) begin
			wr_pend <= acc && hwrite;
			if (acc)
				wr_addr <= haddr[7:0];
			if (acc && !hwrite)
				hrdata <= read_word(haddr[7:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl.addr  <= 17'h00000;
			ctl.wdata <= 19'h00000;
			ctl.mode  <= mbus_pkg::mode_t'(`MODE_RESET);
			ctl.start <= 1'b0;
			ctl.cont  <= 1'b0;
		end else if (ce) begin
			ctl.start <= 1'b0;
			ctl.cont  <= 1'b0;
			if (wr_pend) begin
				case (wr_addr)
				`OFF_ADDR:  ctl.addr  <= hwdata[16:0];
				`OFF_WDATA: ctl.wdata <= hwdata[18:0];
				`OFF_CTRL: begin
					if (!ctl.busy)
						ctl.mode <= mbus_pkg::mode_t'(
							hwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
					ctl.start <= hwdata[`CTRL_START] && !ctl.busy;
					ctl.cont  <= hwdata[`CTRL_CONT] && ctl.pause;
				end
				default: ;
				endcase
			end
		end
	end

	// Completion wins over the clear made by a new start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			done_flag <= 1'b0;
		else if (ce) begin
			if (ctl.done)
				done_flag <= 1'b1;
			else if (ctl.start)
				done_flag <= 1'b0;
		end
	end
endmodule

// >>> mbus_requester.sv
/*
 * Requester for an asynchronous core memory bus: runs read/restore,
 * clear/write and read/pause/write cycles on software command.
 * Assumes bus inputs synchronous to hclk; the board resolves each
 * two-way line from its output enable.
 */
`timescale 1ns/100ps
`include "mbus_consts.svh"
module mbus_requester #(
	parameter int TMR_W = 4
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Shared data lines and parity, two-way
	input  wire logic [17:0] data_in,
	output logic      [17:0] data_out,
	output logic             data_oe_n,
	input  wire logic        parity_in,
	output logic             parity_out,
	output logic             parity_oe_n,
	// Control lines to memory
	output logic             read_mode_line_n,
	output logic             write_mode_line_n,
	output logic             req_n,
	output logic             data_ack_n,
	output logic             release_line_n,
	// Control lines from memory
	input  wire logic        busy_n,
	input  wire logic        addr_ack_n,
	input  wire logic        rd_restart_n,
	input  wire logic        release_accept_n
);
	ctl_if ctl ();

	mbus_pkg::state_t st;
	mbus_pkg::mode_t  cur_mode;
	logic             tmr_exp;
	logic             cap;

	ahb_regs u_regs (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.ctl       (ctl.regs)
	);

	settle_timer #(
		.W     (TMR_W),
		.LIMIT (`SETTLE_CYC)
	) u_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.run     (st == mbus_pkg::ST_ASET || st == mbus_pkg::ST_DSET),
		.expired (tmr_exp)
	);

	// Line low means one, so every driven word is inverted
	function automatic logic [17:0] to_lines(input logic [17:0] w);
		to_lines = ~w;
	endfunction

	assign cap = (st == mbus_pkg::ST_RDV) && !rd_restart_n;

	// Cycle sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st       <= mbus_pkg::ST_IDLE;
			cur_mode <= mbus_pkg::MODE_NONE;
		end else if (ce) begin
			case (st)
			mbus_pkg::ST_IDLE: begin
				if (ctl.start && ctl.mode != mbus_pkg::MODE_NONE) begin
					cur_mode <= ctl.mode;
					st       <= mbus_pkg::ST_FREE;
				end
			end
			mbus_pkg::ST_FREE:
				if (busy_n)
					st <= mbus_pkg::ST_ASET;
			mbus_pkg::ST_ASET:
				if (tmr_exp)
					st <= mbus_pkg::ST_AACK;
			mbus_pkg::ST_AACK: begin
				if (!addr_ack_n && !req_n) begin
					if (cur_mode == mbus_pkg::MODE_CW)
						st <= mbus_pkg::ST_DSET;
					else
						st <= mbus_pkg::ST_RDV;
				end
			end
			mbus_pkg::ST_RDV: begin
				if (cap) begin
					if (cur_mode == mbus_pkg::MODE_RPW)
						st <= mbus_pkg::ST_PAUSE;
					else
						st <= mbus_pkg::ST_RACK;
				end
			end
			mbus_pkg::ST_PAUSE:
				if (ctl.cont)
					st <= mbus_pkg::ST_DSET;
			mbus_pkg::ST_DSET:
				if (tmr_exp)
					st <= mbus_pkg::ST_RACK;
			mbus_pkg::ST_RACK:
				if (!release_accept_n)
					st <= mbus_pkg::ST_END;
			mbus_pkg::ST_END:
				if (release_accept_n && busy_n)
					st <= mbus_pkg::ST_IDLE;
			default:
				st <= mbus_pkg::ST_IDLE;
			endcase
		end
	end

	// Data lines: address first, then write word where the mode needs it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_out    <= 18'h3FFFF;
			data_oe_n   <= 1'b1;
			parity_out  <= 1'b1;
			parity_oe_n <= 1'b1;
		end else if (ce) begin
			if (st == mbus_pkg::ST_FREE && busy_n) begin
				data_out  <= to_lines({1'b0, ctl.addr});
				data_oe_n <= 1'b0;
			end else if (st == mbus_pkg::ST_AACK && !addr_ack_n) begin
				// Clear/write puts its word on at once; reads let go
				data_out    <= to_lines(ctl.wdata[17:0]);
				parity_out  <= ~ctl.wdata[`PAR_BIT];
				data_oe_n   <= (cur_mode != mbus_pkg::MODE_CW);
				parity_oe_n <= (cur_mode != mbus_pkg::MODE_CW);
			end else if (st == mbus_pkg::ST_PAUSE && ctl.cont) begin
				data_out    <= to_lines(ctl.wdata[17:0]);
				parity_out  <= ~ctl.wdata[`PAR_BIT];
				data_oe_n   <= 1'b0;
				parity_oe_n <= 1'b0;
			end else if (st == mbus_pkg::ST_RACK && !release_accept_n) begin
				data_oe_n   <= 1'b1;
				parity_oe_n <= 1'b1;
			end
		end
	end

	// Mode lines stay put for the whole cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			read_mode_line_n  <= 1'b1;
			write_mode_line_n <= 1'b1;
		end else if (ce) begin
			if (st == mbus_pkg::ST_FREE && busy_n) begin
				read_mode_line_n  <= ~cur_mode[0];
				write_mode_line_n <= ~cur_mode[1];
			end else if (st == mbus_pkg::ST_END && release_accept_n
					&& busy_n) begin
				read_mode_line_n  <= 1'b1;
				write_mode_line_n <= 1'b1;
			end
		end
	end

	// Request and its withdrawal on address acknowledge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			req_n <= 1'b1;
		else if (ce) begin
			if (st == mbus_pkg::ST_ASET && tmr_exp)
				req_n <= 1'b0;
			else if (st == mbus_pkg::ST_AACK && !addr_ack_n)
				req_n <= 1'b1;
		end
	end

	// Data acknowledge and release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_ack_n     <= 1'b1;
			release_line_n <= 1'b1;
		end else if (ce) begin
			if (cap) begin
				data_ack_n <= 1'b0;
				// Pause cycle holds release back until software returns
				release_line_n <= (cur_mode == mbus_pkg::MODE_RPW);
			end else if (st == mbus_pkg::ST_PAUSE && ctl.cont)
				data_ack_n <= 1'b1;
			else if (st == mbus_pkg::ST_DSET && tmr_exp)
				release_line_n <= 1'b0;
			else if (st == mbus_pkg::ST_RACK && !release_accept_n) begin
				release_line_n <= 1'b1;
				data_ack_n     <= 1'b1;
			end
		end
	end

	// Read word is taken only under read-data-valid
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctl.rdata <= 19'h00000;
		else if (ce && cap)
			ctl.rdata <= {~parity_in, ~data_in};
	end

	// Status toward software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl.busy  <= 1'b0;
			ctl.pause <= 1'b0;
			ctl.done  <= 1'b0;
		end else if (ce) begin
			ctl.done <= (st == mbus_pkg::ST_END) && release_accept_n
				&& busy_n;
			ctl.busy  <= (st != mbus_pkg::ST_IDLE) && !ctl.done;
			ctl.pause <= (st == mbus_pkg::ST_PAUSE) && !ctl.cont
				|| (cap && cur_mode == mbus_pkg::MODE_RPW);
		end
	end

	chk_mode_lines_legal: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!req_n |-> !(read_mode_line_n && write_mode_line_n))
		else $error("request without any mode line");

	chk_req_after_settle: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(req_n) |-> !$past(data_oe_n, 2) && !$past(data_oe_n, 1))
		else $error("request raised before address settled");

	chk_start_when_free: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(data_oe_n) && st == mbus_pkg::ST_ASET |-> $past(busy_n))
		else $error("cycle started while bus busy");

	chk_req_withdrawn: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && !addr_ack_n && !req_n |=> req_n)
		else $error("request not withdrawn on address acknowledge");

	chk_capture_valid: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$changed(ctl.rdata) |-> !$past(rd_restart_n))
		else $error("read word taken without read-data-valid");

	chk_ack_with_rls: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(release_line_n) && cur_mode == mbus_pkg::MODE_RR
		|-> $fell(data_ack_n))
		else $error("release and data acknowledge not together");

	chk_release_drop: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && st == mbus_pkg::ST_RACK && !release_accept_n
		|=> release_line_n ##1 (st != mbus_pkg::ST_IDLE || busy_n))
		else $error("release not dropped on release accept");

	chk_cw_no_dack: assert property (
		@(posedge hclk) disable iff (!hresetn)
		cur_mode == mbus_pkg::MODE_CW |-> data_ack_n)
		else $error("data acknowledge in clear/write");

	chk_data_before_rls: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(release_line_n) && cur_mode != mbus_pkg::MODE_RR
		|-> !$past(data_oe_n, 2))
		else $error("release before write word settled");

	chk_addr_width: assert property (
		@(posedge hclk) disable iff (!hresetn)
		st == mbus_pkg::ST_ASET && !data_oe_n |-> data_out[17])
		else $error("address wider than 17 bits");
endmodule

// >>> mem_bank_model.sv
/*
 * Behavioural core memory bank facing the requester's bus pins.
 * Assumes pin levels already resolved; idle lines pulled high.
 */
`timescale 1ns/100ps
module mem_bank_model #(
	parameter logic [1:0] BANK = 2'h0
) (
	// Clock and pacing
	input  wire logic        clk,
	input  wire logic [3:0]  dly,
	// Lines from requester
	input  wire logic [18:0] bus,
	input  wire logic        req_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        dack_n,
	input  wire logic        rls_n,
	// Lines to requester
	output logic             busy_n,
	output logic             aack_n,
	output logic             rrst_n,
	output logic             racc_n,
	output logic             drv,
	output logic      [18:0] dout
);
	logic [18:0] mem [int];
	logic [18:0] mb;
	logic [16:0] a;
	logic        rd;
	logic        wr;

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	initial begin
		{busy_n, aack_n, rrst_n, racc_n} = 4'hF;
		drv = 1'b0;
		dout = 19'h7FFFF;
		forever begin
			@(posedge clk);
			if (!req_n && busy_n && ~bus[4:3] == BANK) begin
				a = ~bus[16:0];
				rd = !rd_n;
				wr = !wr_n;
				tick(dly);
				aack_n <= 1'b0;
				busy_n <= 1'b0;
				do tick(1); while (!req_n);
				aack_n <= 1'b1;
				mb = 19'h0;
				if (rd) begin
					mb = mem.exists(a) ? mem[a] : 19'h0;
					tick(dly);
					dout <= ~mb;
					drv <= 1'b1;
					tick(dly);
					rrst_n <= 1'b0;
					do tick(1); while (dack_n);
					drv <= 1'b0;
				end
				// Clear/write skips the read and keeps buffer clear
				do tick(1); while (rls_n);
				if (wr)
					mb = ~bus;
				mem[a] = mb;
				racc_n <= 1'b0;
				rrst_n <= 1'b1;
				do tick(1); while (!rls_n);
				racc_n <= 1'b1;
				tick(1);
				busy_n <= 1'b1;
			end
		end
	end
endmodule

// >>> tb.sv
/*
 * Self-checking bench for the memory bus requester.
 * Assumes the bank model above and a pulled-up shared bus.
 */
`timescale 1ns/100ps
`include "mbus_consts.svh"
module tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [17:0] data_out;
	logic        data_oe_n;
	logic        parity_out;
	logic        parity_oe_n;
	logic        rd_n;
	logic        wr_n;
	logic        req_n;
	logic        data_ack_n;
	logic        rls_n;
	logic        busy_n;
	logic        aack_n;
	logic        rrst_n;
	logic        racc_n;
	logic        drv;
	logic [18:0] dout;
	logic [18:0] bus;
	logic [3:0]  dly;
	logic        saw_dack;
	logic        saw_rrst;
	logic        req_q;
	logic [19:0] cap;
	int          settle;
	int          set_cnt;
	int          n_fail;
	int          n_checks;
	logic [31:0] r;

	localparam logic [16:0] A  = 17'h10A02;
	localparam logic [18:0] D1 = 19'h5A5C3;
	localparam logic [18:0] D2 = 19'h30F0E;

	assign bus[17:0] = !data_oe_n ? data_out : drv ? dout[17:0] : 18'h3FFFF;
	assign bus[18] = !parity_oe_n ? parity_out : drv ? dout[18] : 1'b1;

	mbus_requester DUT (
		.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .data_in(bus[17:0]),
		.data_out(data_out), .data_oe_n(data_oe_n),
		.parity_in(bus[18]), .parity_out(parity_out),
		.parity_oe_n(parity_oe_n), .read_mode_line_n(rd_n),
		.write_mode_line_n(wr_n), .req_n(req_n), .data_ack_n(data_ack_n),
		.release_line_n(rls_n), .busy_n(busy_n), .addr_ack_n(aack_n),
		.rd_restart_n(rrst_n), .release_accept_n(racc_n)
	);

	mem_bank_model u_mem (
		.clk(hclk), .dly(dly), .bus(bus), .req_n(req_n), .rd_n(rd_n),
		.wr_n(wr_n), .dack_n(data_ack_n), .rls_n(rls_n),
		.busy_n(busy_n), .aack_n(aack_n), .rrst_n(rrst_n),
		.racc_n(racc_n), .drv(drv), .dout(dout)
	);

	initial hclk = 1'b0;
	always #20 hclk = ~hclk;

	// Pin watch: settle count and levels at the request edge
	always @(posedge hclk) begin
		req_q <= req_n;
		if (!data_ack_n)
			saw_dack <= 1'b1;
		if (!rrst_n)
			saw_rrst <= 1'b1;
		if (!data_oe_n && req_n)
			settle <= settle + 1;
		else if (data_oe_n)
			settle <= 0;
		if (!req_n && req_q) begin
			set_cnt <= settle;
			cap <= {rd_n, wr_n, bus[17:0]};
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			finish_test;
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask

	task automatic poll(input logic [31:0] mask, input logic [31:0] val);
		int n;
		for (n = 0; n < 300; n++) begin
			xfer(1'b0, `OFF_STATUS, 32'h0, r);
			if ((r & mask) === val)
				return;
		end
		n_fail++;
		finish_test;
	endtask

	task automatic start(input logic [1:0] m, input logic [18:0] d);
		saw_dack <= 1'b0;
		saw_rrst <= 1'b0;
		xfer(1'b1, `OFF_ADDR, {15'h0, A}, r);
		xfer(1'b1, `OFF_WDATA, {13'h0, d}, r);
		xfer(1'b1, `OFF_CTRL, {26'h0, 4'h4, m}, r);
		// Done clears on the start pulse, a clock before busy shows
		poll(32'h1, 32'h1);
	endtask

	task automatic t_reset;
		chk({27'h0, req_n, data_ack_n, rls_n, rd_n, data_oe_n}, 32'h1F);
		xfer(1'b0, `OFF_STATUS, 32'h0, r);
		chk(r, 32'h0);
		xfer(1'b0, `OFF_CTRL, 32'h0, r);
		chk(r, 32'h1);
		xfer(1'b1, 8'h14, 32'hFFFF, r);
		xfer(1'b0, 8'h14, 32'h0, r);
		chk(r, 32'h0);
		$display("reset test done");
	endtask

	task automatic t_clear_write;
		dly = 4'h1;
		start(2'h2, D1);
		poll(32'h7, 32'h4);
		chk({12'h0, cap}, {12'h0, 2'b10, 1'b1, ~A});
		chk({31'h0, set_cnt >= 2}, 32'h1);
		chk({31'h0, saw_dack}, 32'h0);
		chk({31'h0, saw_rrst}, 32'h0);
		chk({13'h0, u_mem.mem[A]}, {13'h0, D1});
		$display("clear/write test done");
	endtask

	task automatic t_read_restore;
		dly = 4'h6;
		for (int i = 0; i < 2; i++) begin
			start(2'h1, 19'h0);
			poll(32'h7, 32'h4);
			xfer(1'b0, `OFF_RDATA, 32'h0, r);
			chk(r, {13'h0, D1});
			chk({31'h0, saw_dack}, 32'h1);
			chk({30'h0, cap[19:18]}, 32'h1);
		end
		$display("read/restore test done");
	endtask

	task automatic t_pause_write;
		dly = 4'h2;
		start(2'h3, 19'h0);
		poll(32'h3, 32'h3);
		chk({31'h0, busy_n}, 32'h0);
		xfer(1'b0, `OFF_RDATA, 32'h0, r);
		chk(r, {13'h0, D1});
		chk({31'h0, rls_n}, 32'h1);
		xfer(1'b1, `OFF_WDATA, {13'h0, D2}, r);
		xfer(1'b1, `OFF_CTRL, 32'h23, r);
		poll(32'h7, 32'h4);
		chk({13'h0, u_mem.mem[A]}, {13'h0, D2});
		chk({30'h0, cap[19:18]}, 32'h0);
		$display("read/pause/write test done");
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		dly = 4'h1;
		n_fail = 0;
		n_checks = 0;
		settle = 0;
		set_cnt = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_clear_write;
		t_read_restore;
		t_pause_write;
		finish_test;
	end
endmodule
